// ===== hdl/mba_pkg.sv
// constants and types shared by the multiprocessor bus arbitration block
// assumes a single system clock; request, host, chip select and dma pin levels are active low on the wire
package mba_pkg;
   localparam int          PROC_CNT     = 6;              // bus request lines 1..6
   localparam int          ID_W         = 3;              // identity input width
   localparam int          DMA_CH       = 2;              // external dma channels a and b
   localparam logic [2:0]  ID_SINGLE    = 3'h0;           // single processor system
   localparam logic [2:0]  ID_NONE      = 3'h0;           // no owner / no winner
   localparam logic [2:0]  ID_IDLE_DRV  = 3'h1;           // drives host grant while bus is idle
   localparam logic [2:0]  ID_MAX       = 3'h6;           // highest legal identity
   localparam int          DMA_A        = 0;              // channel index of dma_req_a
   localparam int          DMA_B        = 1;              // channel index of dma_req_b

   typedef enum logic [1:0]
   {
      MBA_IDLE  = 2'b00,                                  // nobody holds the bus
      MBA_OWNED = 2'b01,                                  // a processor holds the bus
      MBA_HOST  = 2'b10                                   // host holds the bus
   } mba_state_t;
endpackage

// ===== hdl/mba_arb_if.sv
// carries the sampled requests and the winner between control and priority logic
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface mba_arb_if;
   logic [5:0] req;                                       // sampled request lines, bit 0 is line 1
   logic [2:0] last;                                      // last owner, 0 when none
   logic       rotate;                                    // rotating priority selected
   logic [2:0] winner;                                    // winning line number, 0 when none

   modport arb
   (
      input  req,
      input  last,
      input  rotate,
      output winner
   );
   modport ctl
   (
      output req,
      output last,
      output rotate,
      input  winner
   );
endinterface

// ===== hdl/mba_prio_arb.sv
// priority search over the six request lines, fixed or rotating
// assumes requests are already synchronised and identical on every processor
`timescale 1ns/100ps
module mba_prio_arb
(
   mba_arb_if.arb arb_bus                                 // requests in, winner out
);
   always_comb
   begin
      int  start;
      int  cand;
      logic found;
      start = 0;
      cand  = 0;
      found = 1'b0;
      arb_bus.winner = mba_pkg::ID_NONE;
      if (arb_bus.rotate)
      begin
         start = int'(arb_bus.last);                      // last owner searched last
      end
      for (int k = 1; k <= mba_pkg::PROC_CNT; k++)
      begin
         cand = ((start + k - 1) % mba_pkg::PROC_CNT) + 1;
         if (!found && arb_bus.req[cand - 1])
         begin
            found = 1'b1;
            arb_bus.winner = cand[2:0];
         end
      end
   end
endmodule // mba_prio_arb

// ===== hdl/mba_top.sv
// external bus arbitration, dma grant and host wait logic of one processor
// assumes pins are resolved outside; request, identity, priority, host, chip select and dma request inputs are synchronised here
`timescale 1ns/100ps
module mba_top
(
   input  wire logic       clk_i,                         // system clock, 10 MHz
   input  wire logic       rst_i,                         // synchronous reset, active high
   input  wire logic [2:0] proc_identity_i,               // identity strap
   input  wire logic       rotating_prio_sel_i,           // high: rotating priority
   input  wire logic [5:0] mp_bus_req_n_i,                // request lines as seen on the wire
   output logic      [5:0] mp_bus_req_n_o,                // request line drive level
   output logic      [5:0] mp_bus_req_n_oe_o,             // request line drive enable
   input  wire logic       core_bus_req_i,                // core wants the external bus
   output logic            bus_owner_out_o,               // high while bus master
   output logic            ext_bus_hiz_o,                 // address, data, select, strobes released
   input  wire logic       host_bus_req_n_i,              // host bus request, active low
   input  wire logic       chip_sel_n_i,                  // host chip select, active low
   input  wire logic       iop_wait_i,                    // io processor needs wait states
   output logic            host_ack_o,                    // host_ack level, always low
   output logic            host_ack_oe_o,                 // host_ack open-drain enable
   output logic            host_bus_grant_n_o,            // host grant level
   output logic            host_bus_grant_oe_o,           // host grant drive enable
   input  wire logic       dma_req_a_n_i,                 // dma request channel a, active low
   input  wire logic       dma_req_b_n_i,                 // dma request channel b, active low
   input  wire logic [1:0] dma_enable_i,                  // core accepts dma per channel
   output logic            dma_grant_a_n_o,               // dma grant channel a level
   output logic            dma_grant_a_oe_o,              // dma grant channel a enable
   output logic            dma_grant_b_n_o,               // dma grant channel b level
   output logic            dma_grant_b_oe_o,              // dma grant channel b enable
   output logic      [1:0] dma_start_o                    // pulse: dma transfer starts
);
   logic [5:0]              req_s1;
   logic [5:0]              req_s2;
   logic [2:0]              id_s1;
   logic [2:0]              id_s2;
   logic [4:0]              ctl_s1;
   logic [4:0]              ctl_s2;
   logic [2:0]              id;
   logic                    own_req;
   logic [1:0]              grant;
   mba_pkg::mba_state_t     state;
   logic [2:0]              owner;
   logic [2:0]              last;
   logic                    host_grant;
   logic                    single;
   logic                    master;
   logic                    host_req;
   logic                    host_cs;
   logic                    rotate;
   logic [1:0]              dma_req;
   logic                    grant_drv;
   mba_arb_if               arb_bus();

   // two flop synchronisers for the request, identity, priority select, host, chip select and dma request inputs
   always_ff @(posedge clk_i)
   begin
      req_s1 <= ~mp_bus_req_n_i;
      req_s2 <= req_s1;
      id_s1  <= proc_identity_i;
      id_s2  <= id_s1;
      ctl_s1 <= {rotating_prio_sel_i, ~host_bus_req_n_i, ~chip_sel_n_i, ~dma_req_b_n_i, ~dma_req_a_n_i};
      ctl_s2 <= ctl_s1;
   end

   assign rotate   = ctl_s2[4];
   assign host_req = ctl_s2[3];
   assign host_cs  = ctl_s2[2];
   assign dma_req  = ctl_s2[1:0];

   // identity captured while reset is held, static afterwards
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         id <= (id_s2 > mba_pkg::ID_MAX) ? mba_pkg::ID_SINGLE : id_s2;
      end
   end

   assign single = (id == mba_pkg::ID_SINGLE);

   // own request line
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         own_req <= 1'b0;
      end
      else
      begin
         own_req <= core_bus_req_i;
      end
   end

   always_comb
   begin
      mp_bus_req_n_o    = 6'h3f;
      mp_bus_req_n_oe_o = 6'h00;
      for (int i = 1; i <= mba_pkg::PROC_CNT; i++)
      begin
         if (id == i[2:0])
         begin
            mp_bus_req_n_oe_o[i - 1] = !rst_i;
            mp_bus_req_n_o[i - 1]    = !own_req;
         end
      end
   end

   assign arb_bus.req    = req_s2;
   assign arb_bus.last   = last;
   assign arb_bus.rotate = rotate;

   mba_prio_arb u_prio
   (
      .arb_bus (arb_bus)
   );

   // ownership tracked identically on every processor
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= mba_pkg::MBA_IDLE;
         owner <= mba_pkg::ID_NONE;
         last  <= mba_pkg::ID_NONE;
      end
      else
      begin
         unique case (state)
            mba_pkg::MBA_IDLE:
            begin
               if (host_req)
               begin
                  state <= mba_pkg::MBA_HOST;
               end
               else if (arb_bus.winner != mba_pkg::ID_NONE)
               begin
                  state <= mba_pkg::MBA_OWNED;
                  owner <= arb_bus.winner;
                  last  <= arb_bus.winner;
               end
            end
            mba_pkg::MBA_OWNED:
            begin
               if (host_req)
               begin
                  state <= mba_pkg::MBA_HOST;
               end
               else if (!req_s2[owner - 3'h1])
               begin
                  state <= mba_pkg::MBA_IDLE;
                  owner <= mba_pkg::ID_NONE;
               end
            end
            mba_pkg::MBA_HOST:
            begin
               if (!host_req)
               begin
                  state <= mba_pkg::MBA_IDLE;
                  owner <= mba_pkg::ID_NONE;
               end
            end
            default:
            begin
               state <= mba_pkg::MBA_IDLE;
               owner <= mba_pkg::ID_NONE;
            end
         endcase
      end
   end

   assign master = single || (state == mba_pkg::MBA_OWNED && owner == id);
   assign bus_owner_out_o = master;

   // host grant: floats one cycle, then driven by the releasing master, or by identity 1 if the bus was idle
   assign grant_drv = single || (owner != mba_pkg::ID_NONE ? owner == id : id == mba_pkg::ID_IDLE_DRV);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         host_grant <= 1'b0;
      end
      else
      begin
         host_grant <= (state == mba_pkg::MBA_HOST) && host_req;
      end
   end

   assign ext_bus_hiz_o       = (state == mba_pkg::MBA_HOST) && grant_drv;
   assign host_bus_grant_n_o  = !host_grant;
   assign host_bus_grant_oe_o = host_grant && grant_drv;

   assign host_ack_o    = 1'b0;
   assign host_ack_oe_o = host_cs && host_req && iop_wait_i;

   // one cycle dma grant, transfer starts on the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         grant       <= 2'h0;
         dma_start_o <= 2'h0;
      end
      else
      begin
         for (int c = 0; c < mba_pkg::DMA_CH; c++)
         begin
            grant[c] <= master && dma_req[c] && dma_enable_i[c] && !grant[c] && !dma_start_o[c];
         end
         dma_start_o <= grant;
      end
   end

   assign dma_grant_a_n_o  = !grant[mba_pkg::DMA_A];
   assign dma_grant_b_n_o  = !grant[mba_pkg::DMA_B];
   assign dma_grant_a_oe_o = master;
   assign dma_grant_b_oe_o = master;

   // checks
   function automatic logic [2:0] lowest(input logic [5:0] r);
      lowest = mba_pkg::ID_NONE;
      for (int i = mba_pkg::PROC_CNT; i >= 1; i--)
      begin
         if (r[i - 1])
         begin
            lowest = i[2:0];
         end
      end
   endfunction

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_host_wait_ack: assert property ((host_cs && host_req && iop_wait_i) |-> (host_ack_oe_o && !host_ack_o))
      else $error("host_ack not pulled low during wait");
   chk_grant_then_start: assert property ($fell(dma_grant_a_n_o) |=> (dma_start_o[0] && dma_grant_a_n_o))
      else $error("dma a start does not follow grant");
   chk_grant_b_start: assert property (!dma_grant_b_n_o |-> ##1 dma_start_o[1] ##1 !dma_start_o[1])
      else $error("dma b start pulse wrong");
   chk_grant_master_only: assert property (!bus_owner_out_o |-> (!dma_grant_a_oe_o && !dma_grant_b_oe_o && dma_grant_a_n_o))
      else $error("dma grant driven by non master");
   chk_own_line_only: assert property ($countones(mp_bus_req_n_oe_o) == ((id != mba_pkg::ID_SINGLE) ? 1 : 0))
      else $error("wrong number of request lines driven");
   chk_own_line_index: assert property ((id != mba_pkg::ID_SINGLE) |-> mp_bus_req_n_oe_o[id - 3'h1])
      else $error("request line does not match identity");
   chk_owner_tracks: assert property ((!single && state == mba_pkg::MBA_OWNED && owner == id)
      |-> (bus_owner_out_o and (host_req |=> !bus_owner_out_o)))
      else $error("bus owner output wrong");
   chk_single_owner: assert property (single |-> bus_owner_out_o)
      else $error("single processor not bus owner");
   chk_host_wins: assert property ((state != mba_pkg::MBA_HOST && host_req) |=> (state == mba_pkg::MBA_HOST) ##1 host_grant)
      else $error("host request not granted");
   chk_fixed_lowest: assert property ((state == mba_pkg::MBA_IDLE && !host_req && !rotate && req_s2 != 6'h00) |=> (owner == lowest($past(req_s2))))
      else $error("fixed priority winner wrong");
   chk_rotate_last: assert property ((state == mba_pkg::MBA_IDLE && !host_req && rotate && $countones(req_s2) > 1 && last != mba_pkg::ID_NONE) |=> (owner != $past(last)))
      else $error("rotating priority let last owner win");

   cov_host_grant: cover property (host_grant && grant_drv);
   cov_rotate_handoff: cover property (rotate && state == mba_pkg::MBA_OWNED ##1 state == mba_pkg::MBA_IDLE ##1 state == mba_pkg::MBA_OWNED);
   cov_dma_a: cover property (!dma_grant_a_n_o ##1 dma_start_o[0]);
   cov_host_wait: cover property (host_ack_oe_o [*3]);
endmodule // mba_top

// ===== sim/mba_peer_model.sv
// peer processors on the shared request lines, with the board pull-ups
// assumes the bench says which peer lines request; the block's own line comes from its drive
`timescale 1ns/100ps
module mba_peer_model
(
   input  wire logic [5:0] peer_req_i,                    // peer lines pulled low on request
   input  wire logic [5:0] own_n_i,                       // block drive level
   input  wire logic [5:0] own_oe_i,                      // block drive enable
   output logic      [5:0] wire_n_o                       // resolved request lines
);
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         // a line the block drives is also pulled low by a peer request, every other is pulled low by its peer request alone
         if (own_oe_i[i])
            wire_n_o[i] = own_n_i[i] & ~peer_req_i[i];
         else
            wire_n_o[i] = ~peer_req_i[i];
      end
   end
endmodule // mba_peer_model

// ===== sim/multiproc_bus_arbitration_tb.sv
// self-checking bench for the bus arbitration block
// assumes one 10 MHz clock; peers modelled on the request lines only
`timescale 1ns/100ps
module multiproc_bus_arbitration_tb;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [2:0] id = 3'h0;
   logic       rot = 1'b0;
   logic       core = 1'b0;
   logic       hbr_n = 1'b1;
   logic       cs_n = 1'b1;
   logic       iwait = 1'b0;
   logic [1:0] dreq_n = 2'h3;
   logic [1:0] den = 2'h0;
   logic [5:0] peer = 6'h00;
   logic [5:0] wire_n, req_n, req_oe;
   logic       owner, hiz, ack, ack_oe, hbg_n, hbg_oe, ga_n, ga_oe, gb_n, gb_oe;
   logic [1:0] dstart;
   int         miscompares = 0;
   int         n_tests = 0;

   always #50 clk_i = ~clk_i;

   mba_peer_model mba_peer_model_inst (.peer_req_i(peer), .own_n_i(req_n), .own_oe_i(req_oe), .wire_n_o(wire_n));

   mba_top mba_top_inst (.clk_i(clk_i), .rst_i(rst_i), .proc_identity_i(id), .rotating_prio_sel_i(rot),
      .mp_bus_req_n_i(wire_n), .mp_bus_req_n_o(req_n), .mp_bus_req_n_oe_o(req_oe), .core_bus_req_i(core),
      .bus_owner_out_o(owner), .ext_bus_hiz_o(hiz), .host_bus_req_n_i(hbr_n), .chip_sel_n_i(cs_n),
      .iop_wait_i(iwait), .host_ack_o(ack), .host_ack_oe_o(ack_oe), .host_bus_grant_n_o(hbg_n),
      .host_bus_grant_oe_o(hbg_oe), .dma_req_a_n_i(dreq_n[0]), .dma_req_b_n_i(dreq_n[1]),
      .dma_enable_i(den), .dma_grant_a_n_o(ga_n), .dma_grant_a_oe_o(ga_oe), .dma_grant_b_n_o(gb_n),
      .dma_grant_b_oe_o(gb_oe), .dma_start_o(dstart));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error t=%0t %s got %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // identity and priority only change while reset is held
   task automatic do_reset(input logic [2:0] new_id, input logic new_rot);
      @(posedge clk_i);
      rst_i <= 1'b1;
      id    <= new_id;
      rot   <= new_rot;
      core  <= 1'b0;
      peer  <= 6'h00;
      hbr_n <= 1'b1;
      cs_n  <= 1'b1;
      iwait <= 1'b0;
      dreq_n <= 2'h3;
      den   <= 2'h0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      cyc(1);
   endtask

   task automatic set_core(input logic v, input int n);
      @(posedge clk_i);
      core <= v;
      cyc(n);
   endtask

   task automatic t_single;
      do_reset(3'h0, 1'b0);
      chk(owner, 1, "single owner idle");
      chk(req_oe, 0, "single no drive");
      set_core(1'b1, 6);
      chk(owner, 1, "single owner busy");
      set_core(1'b0, 6);
      chk(owner, 1, "single owner after");
   endtask

   task automatic t_ids;
      for (int i = 1; i <= 6; i++)
      begin
         do_reset(i[2:0], 1'b0);
         chk(req_oe, 8'h01 << (i - 1), "own line enable");
         chk(owner, 0, "not owner at start");
         set_core(1'b1, 2);
         chk(req_n, ~(8'h01 << (i - 1)) & 8'h3f, "own line low");
         cyc(6);
         chk(owner, 1, "owner granted");
         chk({ga_oe, gb_oe}, 2'h3, "master drives grants");
         set_core(1'b0, 6);
         chk(owner, 0, "owner released");
         chk({ga_oe, gb_oe}, 2'h0, "grants off");
      end
   endtask

   task automatic t_fixed;
      do_reset(3'h3, 1'b0);
      @(posedge clk_i);
      core <= 1'b1;
      @(posedge clk_i);
      peer <= 6'h01;
      cyc(8);
      chk(owner, 0, "fixed lower line wins");
      @(posedge clk_i);
      peer <= 6'h00;
      cyc(8);
      chk(owner, 1, "fixed takes over");
      set_core(1'b0, 6);
   endtask

   task automatic t_rotate(input logic r);
      do_reset(3'h1, r);
      set_core(1'b1, 8);
      chk(owner, 1, "first ownership");
      set_core(1'b0, 6);
      @(posedge clk_i);
      core <= 1'b1;
      @(posedge clk_i);
      peer <= 6'h02;
      cyc(8);
      chk(owner, !r, "last owner priority");
      @(posedge clk_i);
      peer <= 6'h00;
      cyc(8);
      chk(owner, 1, "owner after peer");
      set_core(1'b0, 6);
   endtask

   task automatic dma_one(input int ch);
      @(posedge clk_i);
      dreq_n[ch] <= 1'b0;
      for (int k = 0; k < 10 && {gb_n, ga_n} !== ~(2'h1 << ch); k++)
         cyc(1);
      chk({gb_n, ga_n}, ~(2'h1 << ch) & 2'h3, "grant pulse");
      @(posedge clk_i);
      dreq_n[ch] <= 1'b1;
      cyc(0);
      @(negedge clk_i);
      chk(dstart, 2'h1 << ch, "start after grant");
      chk({gb_n, ga_n}, 2'h3, "grant one cycle");
      cyc(6);
   endtask

   task automatic t_dma;
      do_reset(3'h2, 1'b0);
      @(posedge clk_i);
      den <= 2'h3;
      set_core(1'b1, 8);
      dma_one(0);
      dma_one(1);
      @(posedge clk_i);
      den    <= 2'h0;
      dreq_n <= 2'h0;
      for (int k = 0; k < 6; k++)
      begin
         cyc(1);
         chk({gb_n, ga_n, dstart}, 4'hc, "no grant while disabled");
      end
      set_core(1'b0, 6);
      @(posedge clk_i);
      den    <= 2'h3;
      dreq_n <= 2'h0;
      for (int k = 0; k < 8; k++)
      begin
         cyc(1);
         chk({gb_oe, ga_oe, dstart}, 4'h0, "no grant off master");
      end
   endtask

   task automatic t_host;
      do_reset(3'h1, 1'b0);
      @(posedge clk_i);
      hbr_n <= 1'b0;
      cs_n  <= 1'b0;
      iwait <= 1'b1;
      core  <= 1'b1;
      for (int k = 0; k < 10 && hbg_oe !== 1'b1; k++)
         cyc(1);
      chk({hbg_oe, hbg_n}, 2'h2, "host granted");
      chk({owner, hiz}, 2'h1, "bus released to host");
      chk({ack_oe, ack}, 2'h2, "host wait asserted");
      cyc(6);
      chk(owner, 0, "host beats processor");
      @(posedge clk_i);
      iwait <= 1'b0;
      cyc(1);
      chk(ack_oe, 0, "host wait ends");
      @(posedge clk_i);
      hbr_n <= 1'b1;
      cs_n  <= 1'b1;
      cyc(8);
      chk({hbg_oe, hiz, owner}, 3'h1, "host done, core owns");
      @(posedge clk_i);
      hbr_n <= 1'b0;
      cyc(5);
      chk({hbg_oe, hbg_n, owner, hiz}, 4'h9, "host takes owned bus");
      @(posedge clk_i);
      hbr_n <= 1'b1;
      cyc(8);
      chk({hbg_oe, hiz, owner}, 3'h1, "owner back after host");
      set_core(1'b0, 6);
   endtask

   initial
   begin
      #500000;
      miscompares++;
      stop_test();
   end

   initial
   begin
      t_single();
      t_ids();
      t_fixed();
      t_rotate(1'b0);
      t_rotate(1'b1);
      t_dma();
      t_host();
      stop_test();
   end
endmodule // multiproc_bus_arbitration_tb
